/* File: logic/cmg_mask_gate.sv */
// Functional notes
// - Gate B true enable set puts true mask B into the AND gate.
// - Gate B inverted enable set puts inverted mask B into the AND gate.
// - Gate A true enable set puts true mask A into the AND gate.
// - Gate A inverted enable set puts inverted mask A into the AND gate.
// - Four-bit selector picks mask A source; PWM codes 0-5, reserved codes, trigger at 1100-1101, fault at 1110-1111.
`timescale 1ns/100ps
`include "cmg_regs.svh"
module cmg_mask_gate (
    // Clock, reset, enable
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST,
    input  wire logic                          CE,
    // APB slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [`CMG_ADDR_W-1:0]        PADDR,
    input  wire logic [31:0]                   PWDATA,
    input  wire logic [3:0]                    PSTRB,
    output logic      [31:0]                   PRDATA,
    output logic                               PREADY,
    output logic                               PSLVERR,
    // Mask sources
    input  wire logic [`CMG_NUM_PWM-1:0]       PWM_OUT,
    input  wire logic [`CMG_NUM_TRIG-1:0]      TRIG_OUT,
    input  wire logic [`CMG_NUM_FAULT-1:0]     FAULT_IN,
    input  wire logic                          MASK_INPUT_B,
    // Gate result
    output logic                               AND_GATE_OUT
);
    import cmg_pkg::*;

    typedef struct packed {
        cmg_apb_state_t              apb;
        logic [`CMG_CTRL_W-1:0]      ctrl;
        logic [`CMG_SEL_W-1:0]       sel;
        logic                        mask_a;
        logic                        mask_b;
        logic                        rsvd_sel;
        logic [31:0]                 rdata;
        logic                        slverr;
        logic                        gate_q;
        logic                        ready;
    } cmg_state_t;

    cmg_state_t  state;
    cmg_state_t  next_state;
    logic        src_a;
    logic        wr_ok;
    logic        rd_hit;
    logic [31:0] rd_val;
    logic [31:0] wmask;
    cmg_gate_if  gif();

    // Byte strobes expand to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_strb
            assign wmask[g*8 +: 8] = {8{PSTRB[g]}};
        end
    endgenerate

    // Mask A source decode
    always_comb begin
        src_a = 1'b0;
        if (state.sel <= `CMG_SEL_PWM_LAST) begin
            src_a = PWM_OUT[state.sel[2:0]];
        end else if (state.sel == `CMG_SEL_TRIG_A) begin
            src_a = TRIG_OUT[0];
        end else if (state.sel == `CMG_SEL_TRIG_B) begin
            src_a = TRIG_OUT[1];
        end else if (state.sel == `CMG_SEL_FAULT_A) begin
            src_a = FAULT_IN[0];
        end else if (state.sel == `CMG_SEL_FAULT_B) begin
            src_a = FAULT_IN[1];
        end
    end

    // Read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_val = `CMG_ZERO32;
        unique case (PADDR)
            `CMG_OFF_GATE_CTRL: begin
                rd_val[`CMG_CTRL_W-1:0] = state.ctrl;
            end
            `CMG_OFF_SRC_SEL: begin
                rd_val[`CMG_SEL_W-1:0] = state.sel;
            end
            `CMG_OFF_STATUS: begin
                rd_val[`CMG_ST_BIT_GATE]     = state.gate_q;
                rd_val[`CMG_ST_BIT_MASK_A]   = state.mask_a;
                rd_val[`CMG_ST_BIT_MASK_B]   = state.mask_b;
                rd_val[`CMG_ST_BIT_RSVD_SEL] = state.rsvd_sel;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        wr_ok = PSEL & PENABLE & PWRITE;
        // Inputs are registered once so the gate sees glitch-free levels
        next_state.mask_a = src_a;
        next_state.mask_b = MASK_INPUT_B;
        next_state.gate_q = gif.gate_out;
        // Reserved codes give a 0 source; flagged so software can spot misconfiguration
        next_state.rsvd_sel = (state.sel >= `CMG_SEL_RSVD_FIRST) && (state.sel <= `CMG_SEL_RSVD_LAST);
        unique case (state.apb)
            CMG_APB_IDLE: begin
                if (PSEL & PENABLE) begin
                    next_state.apb = CMG_APB_DONE;
                    next_state.ready = 1'b1;
                    next_state.slverr = ~rd_hit;
                    next_state.rdata = (PWRITE | ~rd_hit) ? `CMG_ZERO32 : rd_val;
                    if (wr_ok && PADDR == `CMG_OFF_GATE_CTRL) begin
                        next_state.ctrl = (state.ctrl & ~wmask[`CMG_CTRL_W-1:0])
                                        | (PWDATA[`CMG_CTRL_W-1:0] & wmask[`CMG_CTRL_W-1:0]);
                    end
                    if (wr_ok && PADDR == `CMG_OFF_SRC_SEL && PSTRB[0]) begin
                        next_state.sel = PWDATA[`CMG_SEL_W-1:0];
                    end
                end
            end
            CMG_APB_DONE: begin
                next_state.apb = CMG_APB_IDLE;
                next_state.ready = 1'b0;
                next_state.slverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state.apb      <= CMG_APB_IDLE;
            state.ctrl     <= `CMG_CTRL_RESET;
            state.sel      <= `CMG_SEL_RESET;
            state.mask_a   <= 1'b0;
            state.mask_b   <= 1'b0;
            state.rsvd_sel <= 1'b0;
            state.rdata    <= `CMG_ZERO32;
            state.slverr   <= 1'b0;
            state.gate_q   <= 1'b0;
            state.ready    <= 1'b0;
        end else if (CE) begin
            state <= next_state;
        end
    end

    assign gif.enables      = state.ctrl[`CMG_BIT_B_TRUE_EN:`CMG_BIT_A_INV_EN];
    assign gif.mask_input_a = state.mask_a;
    assign gif.mask_input_b = state.mask_b;

    cmg_and_gate u_gate (
        .clk (CLK_SYS),
        .rst (RST),
        .ce  (CE),
        .gif (gif.gate)
    );

    assign PRDATA       = state.rdata;
    assign PREADY       = state.ready;
    assign PSLVERR      = state.slverr;
    assign AND_GATE_OUT = gif.gate_out;
endmodule : cmg_mask_gate

/* File: logic/cmg_regs.svh */
// Register offsets, field positions and reset values of the comparator mask gating block
`ifndef CMG_REGS_SVH
`define CMG_REGS_SVH

`define CMG_ADDR_W           12
`define CMG_OFF_GATE_CTRL    12'h000
`define CMG_OFF_SRC_SEL      12'h004
`define CMG_OFF_STATUS       12'h008
`define CMG_CTRL_W           16
`define CMG_CTRL_RESET       16'h0000
`define CMG_BIT_A_INV_EN     0
`define CMG_BIT_A_TRUE_EN    1
`define CMG_BIT_B_INV_EN     2
`define CMG_BIT_B_TRUE_EN    3
`define CMG_SEL_W            4
`define CMG_SEL_RESET        4'h0
`define CMG_SEL_PWM_LAST     4'h5
`define CMG_SEL_RSVD_FIRST   4'h6
`define CMG_SEL_RSVD_LAST    4'hB
`define CMG_SEL_TRIG_A       4'hC
`define CMG_SEL_TRIG_B       4'hD
`define CMG_SEL_FAULT_A      4'hE
`define CMG_SEL_FAULT_B      4'hF
`define CMG_NUM_PWM          6
`define CMG_NUM_TRIG         2
`define CMG_NUM_FAULT        2
`define CMG_ST_BIT_GATE      0
`define CMG_ST_BIT_MASK_A    1
`define CMG_ST_BIT_MASK_B    2
`define CMG_ST_BIT_RSVD_SEL  3
`define CMG_ZERO32           32'h0000_0000

`endif

/* File: logic/cmg_pkg.sv */
// Types shared by the comparator mask gating block
package cmg_pkg;
    typedef enum logic [1:0] {
        CMG_APB_IDLE,
        CMG_APB_DONE
    } cmg_apb_state_t;
endpackage : cmg_pkg

/* File: logic/cmg_gate_if.sv */
// Signals passed between the register core and the AND gate stage
`timescale 1ns/100ps
interface cmg_gate_if;
    logic [3:0] enables;
    logic       mask_input_a;
    logic       mask_input_b;
    logic       gate_out;
    modport core (output enables, output mask_input_a, output mask_input_b, input gate_out);
    modport gate (input enables, input mask_input_a, input mask_input_b, output gate_out);
endinterface : cmg_gate_if

/* File: logic/cmg_and_gate.sv */
// AND gate stage with per-input enables, registered output
`timescale 1ns/100ps
`include "cmg_regs.svh"
module cmg_and_gate (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    // Gate signals
    cmg_gate_if.gate   gif
);
    import cmg_pkg::*;

    typedef struct packed {
        logic gate_out;
    } cmg_gate_state_t;

    cmg_gate_state_t state;
    cmg_gate_state_t next_state;
    logic            any_enabled;
    logic            product;

    always_comb begin
        // Disabled inputs are forced to 1 so they drop out of the product
        product = (gif.mask_input_b | ~gif.enables[`CMG_BIT_B_TRUE_EN])
                & (~gif.mask_input_b | ~gif.enables[`CMG_BIT_B_INV_EN])
                & (gif.mask_input_a | ~gif.enables[`CMG_BIT_A_TRUE_EN])
                & (~gif.mask_input_a | ~gif.enables[`CMG_BIT_A_INV_EN]);
        any_enabled = |gif.enables;
        next_state = state;
        next_state.gate_out = any_enabled & product;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign gif.gate_out = state.gate_out;
endmodule : cmg_and_gate

/* File: verif/cmg_mask_gate_assertions.sv */
// Port-level checks of the comparator mask gating block
`timescale 1ns/100ps
`include "cmg_regs.svh"
module cmg_mask_gate_assertions (
    // Clock and reset
    input wire logic                   CLK_SYS,
    input wire logic                   RST,
    input wire logic                   CE,
    // APB
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PWRITE,
    input wire logic [`CMG_ADDR_W-1:0] PADDR,
    input wire logic [31:0]            PWDATA,
    input wire logic                   PREADY,
    // Sources and result
    input wire logic [5:0]             PWM_OUT,
    input wire logic [1:0]             TRIG_OUT,
    input wire logic [1:0]             FAULT_IN,
    input wire logic                   MASK_INPUT_B,
    input wire logic                   AND_GATE_OUT
);
    // Shadows load at the ready edge, behind the design, so checks wait until the whole key holds still
    logic [3:0] ctrl, sel;
    logic [9:0] key_d;
    logic [1:0] cnt;
    logic       ma;
    wire        wr = PSEL && PENABLE && PREADY && PWRITE && CE;
    wire        b = MASK_INPUT_B;
    wire [9:0]  key = {ctrl, sel, ma, b};
    wire        ok = cnt == 2'h3 && key == key_d;
    wire        exp_out = ctrl != 4'h0 && (!ctrl[3] || b) && (!ctrl[2] || !b) && (!ctrl[1] || ma) && (!ctrl[0] || !ma);
    always_comb begin
        ma = 1'b0;
        if (sel <= `CMG_SEL_PWM_LAST)
            ma = PWM_OUT[sel[2:0]];
        else if (sel >= `CMG_SEL_TRIG_A)
            ma = sel[1] ? FAULT_IN[sel[0]] : TRIG_OUT[sel[0]];
    end
    always_ff @(posedge CLK_SYS) begin
        key_d <= key;
        if (RST) begin
            ctrl <= 4'h0;
            sel <= 4'h0;
            cnt <= 2'h0;
        end else begin
            if (wr && PADDR == `CMG_OFF_GATE_CTRL)
                ctrl <= PWDATA[3:0];
            if (wr && PADDR == `CMG_OFF_SRC_SEL)
                sel <= PWDATA[3:0];
            cnt <= (key == key_d && CE) ? cnt + 2'(cnt != 2'h3) : 2'h0;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    AST_B_TRUE: assert property (ok && ctrl == 4'h8 |-> AND_GATE_OUT == b)
        else $error("gate ignores mask B");
    AST_B_INV: assert property (ok && ctrl == 4'h4 |-> AND_GATE_OUT == !b)
        else $error("gate ignores inverted mask B");
    AST_A_TRUE: assert property (ok && ctrl == 4'h2 |-> AND_GATE_OUT == ma)
        else $error("gate ignores mask A");
    AST_A_INV: assert property (ok && ctrl == 4'h1 |-> AND_GATE_OUT == !ma)
        else $error("gate ignores inverted mask A");
    AST_FAULT_SRC: assert property (ok && ctrl == 4'h2 && sel == 4'hF |-> AND_GATE_OUT == FAULT_IN[1])
        else $error("fault source not on mask A");
    AST_AND_ALL: assert property (ok |-> AND_GATE_OUT == exp_out)
        else $error("gate is not the AND of enabled inputs");
    AST_IDLE_ZERO: assert property ($fell(RST) |-> (!AND_GATE_OUT) [*3])
        else $error("gate not low after reset");
endmodule : cmg_mask_gate_assertions
bind cmg_mask_gate cmg_mask_gate_assertions chk_u (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PWM_OUT(PWM_OUT),
    .TRIG_OUT(TRIG_OUT), .FAULT_IN(FAULT_IN), .MASK_INPUT_B(MASK_INPUT_B), .AND_GATE_OUT(AND_GATE_OUT));

/* File: verif/cmg_mask_gate_tb_top.sv */
// Self-checking bench for the comparator mask gating block
`timescale 1ns/100ps
module cmg_mask_gate_tb_top;
    logic        CLK_SYS = 0, RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MASK_INPUT_B = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd, w;
    logic [5:0]  PWM_OUT = 0;
    logic [1:0]  TRIG_OUT = 0, FAULT_IN = 0;
    logic        PREADY, PSLVERR, AND_GATE_OUT, err;
    int          n_errors = 0, total_checks = 0;
    always #12.5 CLK_SYS = ~CLK_SYS;
    // All byte strobes stay high, since the checker shadows ignore them
    cmg_mask_gate dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PWM_OUT(PWM_OUT), .TRIG_OUT(TRIG_OUT), .FAULT_IN(FAULT_IN), .MASK_INPUT_B(MASK_INPUT_B),
        .AND_GATE_OUT(AND_GATE_OUT));
    function automatic logic gate_of(logic [3:0] c, logic a, logic b);
        return c != 4'h0 && (!c[3] || b) && (!c[2] || !b) && (!c[1] || a) && (!c[0] || !a);
    endfunction : gate_of
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        if (n >= 50)
            n_errors++;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : apb
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #500000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        logic       a;
        logic [3:0] c, s;
        void'($urandom(38));
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 12'(k * 4), 32'h0);
            chk("reset read", rd, 32'h0);
            chk("slave error", err, 32'(k == 3));
        end
        $display("reset and map test done");
        // Every control pattern meets every source code, reserved ones included
        for (int i = 0; i < 256; i++) begin
            c = 4'(i >> 4);
            s = 4'(i);
            PWM_OUT <= 6'($urandom);
            TRIG_OUT <= 2'($urandom);
            FAULT_IN <= 2'($urandom);
            MASK_INPUT_B <= 1'($urandom);
            w = $urandom;
            apb(1'b1, 12'h000, {w[31:4], c});
            apb(1'b1, 12'h004, {w[31:4], s});
            repeat (2) @(posedge CLK_SYS);
            a = s <= 4'h5 ? PWM_OUT[s[2:0]] : s >= 4'hE ? FAULT_IN[s[0]] : s >= 4'hC ? TRIG_OUT[s[0]] : 1'b0;
            chk("gate out", AND_GATE_OUT, gate_of(c, a, MASK_INPUT_B));
            apb(1'b0, 12'h008, 32'h0);
            chk("status", rd, {28'h0, s inside {[4'h6:4'hB]}, MASK_INPUT_B, a, gate_of(c, a, MASK_INPUT_B)});
            apb(1'b0, 12'h000, 32'h0);
            chk("gate control", rd, {16'h0, w[15:4], c});
            apb(1'b0, 12'h004, 32'h0);
            chk("source select", rd, {28'h0, s});
        end
        $display("gate sweep done");
        // Clock enable low must hold the gate result while mask B moves
        MASK_INPUT_B <= 1'b1;
        apb(1'b1, 12'h000, 32'h8);
        apb(1'b1, 12'h004, 32'h0);
        repeat (2) @(posedge CLK_SYS);
        chk("gate before freeze", AND_GATE_OUT, 32'h1);
        CE <= 1'b0;
        MASK_INPUT_B <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        chk("gate frozen", AND_GATE_OUT, 32'h1);
        CE <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        chk("gate after freeze", AND_GATE_OUT, 32'h0);
        $display("clock enable test done");
        report_and_stop();
    end
endmodule : cmg_mask_gate_tb_top
